/* hw/agcc_config.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// Gain and channel configuration registers of the audio converter, reached over APB.
module agcc_config
#(
	parameter int NUM_CH   = 4,
	parameter int FAST_CYC = agcc_pkg::STEP_FAST_CYC,
	parameter int SLOW_CYC = agcc_pkg::STEP_SLOW_CYC
)
(
	input  wire logic                               mclk,
	input  wire logic                               rst_n,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [agcc_pkg::ADDR_W-1:0]        paddr,
	input  wire logic [31:0]                        pwdata,
	input  wire logic [3:0]                         pstrb,
	output logic [31:0]                             prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	output logic [3:0]                              enhancer_trigger_threshold,
	output logic [3:0]                              enhancer_gain_ceiling,
	output logic [3:0]                              controller_target_level,
	output logic [3:0]                              controller_gain_ceiling,
	output logic [1:0]                              runtime_gain_change_mode,
	output logic                                    input_chan1_on,
	output logic                                    input_chan2_on,
	output logic                                    input_chan3_on,
	output logic                                    input_chan4_on,
	output logic                                    level_algorithm_select,
	output logic                                    compression_on,
	output logic signed [7:0]                       threshold_db,
	output logic signed [7:0]                       enhancer_ceiling_db,
	output logic signed [7:0]                       target_level_db,
	output logic signed [7:0]                       controller_ceiling_db,
	output logic                                    enhancer_active,
	output logic                                    controller_active,
	input  wire logic [NUM_CH-1:0]                  channel_enhancer_on,
	input  wire logic                               high_impedance_sel,
	input  wire logic [NUM_CH*agcc_pkg::GAIN_W-1:0] requested_gain,
	input  wire logic [NUM_CH-1:0]                  zero_cross,
	output logic [NUM_CH*agcc_pkg::GAIN_W-1:0]      applied_gain
);
	import agcc_pkg::*;

	// Byte addresses of the registers.
	localparam logic [ADDR_W-1:0] A_ALGO_SEL    = ADDR_W'({IDX_ALGO_SEL, 2'b00});
	localparam logic [ADDR_W-1:0] A_ENH_LEVELS  = ADDR_W'({IDX_ENH_LEVELS, 2'b00});
	localparam logic [ADDR_W-1:0] A_CTL_LEVELS  = ADDR_W'({IDX_CTL_LEVELS, 2'b00});
	localparam logic [ADDR_W-1:0] A_GAIN_CHANGE = ADDR_W'({IDX_GAIN_CHANGE, 2'b00});
	localparam logic [ADDR_W-1:0] A_CHAN_EN     = ADDR_W'({IDX_CHAN_EN, 2'b00});

	// Whole register state of the block.
	typedef struct packed {
		logic [7:0]  algo_sel;     // Compression and algorithm selection.
		logic [7:0]  enh_levels;   // Range enhancer threshold and ceiling.
		logic [7:0]  ctl_levels;   // Gain controller target and ceiling.
		logic [7:0]  gain_change;  // Run-time gain change mode.
		logic [7:0]  chan_en;      // Input channel enables.
		logic [31:0] rdata;        // Read data held for the access phase.
		logic        enh_act;      // Range enhancer is the running algorithm.
		logic        ctl_act;      // Gain controller is the running algorithm.
	} agcc_regs_t;

	agcc_regs_t r_reg;    // Registered state.
	agcc_regs_t r_next;   // Next state.
	logic       setup;    // Setup phase of a transfer.
	logic       access;   // Access phase in which the transfer completes.
	logic       mapped;   // Address hits a register.
	logic       lane0;    // Lowest byte lane is written.
	logic [7:0] wbyte;    // Write data of the lowest lane.

	// Returns the read value of the register at an address.
	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a, input agcc_regs_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			A_ALGO_SEL:    v = s.algo_sel & ALGO_SEL_RW;
			A_ENH_LEVELS:  v = s.enh_levels;
			A_CTL_LEVELS:  v = s.ctl_levels;
			A_GAIN_CHANGE: v = s.gain_change & GAIN_CHANGE_RW;
			A_CHAN_EN:     v = s.chan_en & CHAN_EN_RW;
			default:       v = 8'h00;
		endcase
		return v;
	endfunction

	// Returns whether an address names a register.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == A_ALGO_SEL) || (a == A_ENH_LEVELS) || (a == A_CTL_LEVELS) ||
			(a == A_GAIN_CHANGE) || (a == A_CHAN_EN);
	endfunction

	// The slave never inserts wait states.
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign mapped  = is_mapped(paddr);
	assign lane0   = pstrb[0];
	assign wbyte   = pwdata[7:0];
	assign pready  = 1'b1;
	// Unmapped addresses answer with an error and change nothing.
	assign pslverr = access && !mapped;

	// Register updates, read capture and algorithm choice.
	always_comb
	begin
		r_next = r_reg;
		// Read data is captured in setup so it is a flop during access.
		if (setup)
			r_next.rdata = {24'h000000, read_mux(paddr, r_reg)};
		// A write lands only at the completing edge of the access phase.
		if (access && pwrite && lane0)
		begin
			unique case (paddr)
				A_ALGO_SEL:
				begin
					r_next.algo_sel = wbyte & ALGO_SEL_RW;
				end
				A_ENH_LEVELS:
				begin
					// Reserved codes are kept as written; software must avoid them.
					r_next.enh_levels = wbyte;
				end
				A_CTL_LEVELS:
				begin
					r_next.ctl_levels = wbyte;
				end
				A_GAIN_CHANGE:
				begin
					// The reserved read-write bit is stored like any other.
					r_next.gain_change = wbyte & GAIN_CHANGE_RW;
				end
				A_CHAN_EN:
				begin
					r_next.chan_en = wbyte & CHAN_EN_RW;
				end
				default:
				begin
					r_next.chan_en = r_reg.chan_en;
				end
			endcase
		end
		// Compression overrides both level algorithms.
		// algorithm selection
		r_next.enh_act = !r_reg.algo_sel[COMP_BIT] && (|channel_enhancer_on) && !r_reg.algo_sel[SEL_BIT];
		r_next.ctl_act = !r_reg.algo_sel[COMP_BIT] && (|channel_enhancer_on) && r_reg.algo_sel[SEL_BIT];
	end

	// All fields return to their documented values on reset.
	// reset and readback
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg.algo_sel    <= RST_ALGO_SEL;
			r_reg.enh_levels  <= RST_ENH_LEVELS;
			r_reg.ctl_levels  <= RST_CTL_LEVELS;
			r_reg.gain_change <= RST_GAIN_CHANGE;
			r_reg.chan_en     <= RST_CHAN_EN;
			r_reg.rdata       <= 32'h00000000;
			r_reg.enh_act     <= 1'b0;
			r_reg.ctl_act     <= 1'b0;
		end
		else
			r_reg <= r_next;
	end

	// Field outputs come straight from the register flops.
	assign prdata                     = r_reg.rdata;
	assign enhancer_trigger_threshold = r_reg.enh_levels[HI_NIB_LSB +: 4];
	assign enhancer_gain_ceiling      = r_reg.enh_levels[3:0];
	assign controller_target_level    = r_reg.ctl_levels[HI_NIB_LSB +: 4];
	assign controller_gain_ceiling    = r_reg.ctl_levels[3:0];
	assign runtime_gain_change_mode   = r_reg.gain_change[MODE_LSB +: 2];
	assign input_chan1_on             = r_reg.chan_en[CH1_BIT];
	assign input_chan2_on             = r_reg.chan_en[CH1_BIT-1];
	assign input_chan3_on             = r_reg.chan_en[CH1_BIT-2];
	assign input_chan4_on             = r_reg.chan_en[CH1_BIT-3];
	assign level_algorithm_select     = r_reg.algo_sel[SEL_BIT];
	assign compression_on             = r_reg.algo_sel[COMP_BIT];
	assign enhancer_active            = r_reg.enh_act;
	assign controller_active          = r_reg.ctl_act;

	// Decibel views of the four level codes, one cycle after the field.
	// threshold in decibels
	agcc_level_decode u_thr
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.code  (enhancer_trigger_threshold),
		.base  (THR_BASE),
		.step  (THR_STEP),
		.db    (threshold_db)
	);

	agcc_level_decode u_egn
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.code  (enhancer_gain_ceiling),
		.base  (EGN_BASE),
		.step  (EGN_STEP),
		.db    (enhancer_ceiling_db)
	);

	agcc_level_decode u_tgt
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.code  (controller_target_level),
		.base  (TGT_BASE),
		.step  (TGT_STEP),
		.db    (target_level_db)
	);

	agcc_level_decode u_cgn
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.code  (controller_gain_ceiling),
		.base  (CGN_BASE),
		.step  (CGN_STEP),
		.db    (controller_ceiling_db)
	);

	// One gain ramp per channel, all sharing the programmed mode.
	// A limitation: the mode is global, so channels cannot ramp at different rates.
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_ramp
			agcc_gain_ramp #(
				.FAST_CYC (FAST_CYC),
				.SLOW_CYC (SLOW_CYC)
			) u_ramp
			(
				.mclk           (mclk),
				.rst_n          (rst_n),
				.mode           (agcc_gcm_t'(runtime_gain_change_mode)),
				.high_impedance (high_impedance_sel),
				.requested      (requested_gain[ch*GAIN_W +: GAIN_W]),
				.zero_cross     (zero_cross[ch]),
				.applied        (applied_gain[ch*GAIN_W +: GAIN_W])
			);
		end
	endgenerate
endmodule // agcc_config

/* hw/agcc_gain_ramp.sv */
`timescale 1ns/1ps
// Moves one channel's applied gain toward its requested gain.
module agcc_gain_ramp
#(
	parameter int FAST_CYC = agcc_pkg::STEP_FAST_CYC,
	parameter int SLOW_CYC = agcc_pkg::STEP_SLOW_CYC
)
(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire agcc_pkg::agcc_gcm_t       mode,
	input  wire logic                      high_impedance,
	input  wire logic [agcc_pkg::GAIN_W-1:0] requested,
	input  wire logic                      zero_cross,
	output logic [agcc_pkg::GAIN_W-1:0]    applied
);
	import agcc_pkg::*;

	agcc_ramp_t        st_reg;   // Gain and interval counter.
	agcc_ramp_t        st_next;  // Next state.
	logic [GAIN_W-1:0] limit;    // Highest gain allowed in this mode.
	logic [GAIN_W-1:0] target;   // Requested gain after limiting.
	logic [TICK_W-1:0] period;   // One less than the cycles between half-decibel steps.

	// Stepping modes only support a reduced gain range.
	always_comb
	begin
		st_next = st_reg;
		limit   = GAIN_MAX;
		period  = TICK_W'(FAST_CYC - 1);
		if (mode == GCM_STEP_SLOW)
			period = TICK_W'(SLOW_CYC - 1);
		if (mode == GCM_STEP_FAST || mode == GCM_STEP_SLOW)
			limit = high_impedance ? GAIN_LIM_20K : GAIN_LIM_10K;
		target = (requested > limit) ? limit : requested;
		unique case (mode)
			GCM_IMMEDIATE:
			begin
				st_next.gain = target;
				st_next.tick = '0;
			end
			GCM_NO_STEP:
			begin
				// Waiting for a signal crossing avoids a click without stepping.
				if (zero_cross)
					st_next.gain = target;
				st_next.tick = '0;
			end
			GCM_STEP_FAST, GCM_STEP_SLOW:
			begin
				if (st_reg.gain == target)
					st_next.tick = '0;
				else if (st_reg.tick >= period)
				begin
					st_next.tick = '0;
					st_next.gain = (st_reg.gain < target) ? st_reg.gain + 1'b1 : st_reg.gain - 1'b1;
				end
				else
					st_next.tick = st_reg.tick + 1'b1;
			end
		endcase
	end

	// State register.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign applied = st_reg.gain;
endmodule // agcc_gain_ramp

/* hw/agcc_level_decode.sv */
`timescale 1ns/1ps
// Turns one four-bit level code into registered decibels.
module agcc_level_decode
(
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic [3:0]         code,
	input  wire logic signed [7:0]  base,
	input  wire logic signed [7:0]  step,
	output logic signed [7:0]       db
);
	import agcc_pkg::*;

	logic signed [7:0] db_reg;   // Registered decibel value.
	logic signed [7:0] db_next;  // Next decibel value.

	// The gaps between listed codes keep the same spacing.
	// uniform step decode
	always_comb
	begin
		db_next = agcc_code_db(code, base, step);
	end

	// Registered so the output is a flip-flop.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			db_reg <= 8'sh00;
		else
			db_reg <= db_next;
	end

	assign db = db_reg;
endmodule // agcc_level_decode

/* inc/agcc_pkg.sv */
// Summary of operation
// - Threshold field bits 7:4, resets 0111b.
// - Enhancer gain ceiling bits 3:0, resets 1011b.
// - Controller target level bits 7:4, resets 1110b.
// - Controller gain ceiling bits 3:0, resets 0111b.
// - Mode 0 applies new gain at once.
// - Mode 1 applies gain without stepping, reduced artifacts.
// - Mode 2 steps 0.5 dB every 20 us.
// - Mode 3 steps 0.5 dB every 40 us.
// - Channels 1 and 2 enabled after reset.
// - Channels 3 and 4 disabled after reset.
// - Low reserved bits read zero, ignore writes.
// - Select bit picks enhancer or controller algorithm.
package agcc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0]  IDX_ALGO_SEL    = 8'h6c;
	localparam logic [7:0]  IDX_ENH_LEVELS  = 8'h6d;
	localparam logic [7:0]  IDX_CTL_LEVELS  = 8'h70;
	localparam logic [7:0]  IDX_GAIN_CHANGE = 8'h71;
	localparam logic [7:0]  IDX_CHAN_EN     = 8'h73;
	localparam int          ADDR_W          = 12;

	// Reset values of the registers.
	localparam logic [7:0]  RST_ALGO_SEL    = 8'h00;
	localparam logic [7:0]  RST_ENH_LEVELS  = 8'h7b;
	localparam logic [7:0]  RST_CTL_LEVELS  = 8'he7;
	localparam logic [7:0]  RST_GAIN_CHANGE = 8'h00;
	localparam logic [7:0]  RST_CHAN_EN     = 8'hc0;

	// Field positions.
	localparam int          HI_NIB_LSB      = 4;
	localparam int          MODE_LSB        = 6;
	localparam int          RSV_RW_BIT      = 5;
	localparam int          CH1_BIT         = 7;
	localparam int          SEL_BIT         = 3;
	localparam int          COMP_BIT        = 1;
	localparam logic [7:0]  GAIN_CHANGE_RW  = 8'he0;
	localparam logic [7:0]  CHAN_EN_RW      = 8'hf0;
	localparam logic [7:0]  ALGO_SEL_RW     = 8'h0a;

	// Code to decibel mapping: base value and step per code.
	localparam logic signed [7:0] THR_BASE  = -8'sd12;
	localparam logic signed [7:0] THR_STEP  = -8'sd6;
	localparam logic signed [7:0] EGN_BASE  = 8'sd2;
	localparam logic signed [7:0] EGN_STEP  = 8'sd2;
	localparam logic signed [7:0] TGT_BASE  = -8'sd6;
	localparam logic signed [7:0] TGT_STEP  = -8'sd2;
	localparam logic signed [7:0] CGN_BASE  = 8'sd3;
	localparam logic signed [7:0] CGN_STEP  = 8'sd3;

	// Gain in half-decibel codes, limits for the stepping modes.
	localparam int          GAIN_W          = 7;
	localparam logic [6:0]  GAIN_MAX        = 7'h54;
	localparam logic [6:0]  GAIN_LIM_10K    = 7'h3c;
	localparam logic [6:0]  GAIN_LIM_20K    = 7'h30;

	// Stepping intervals.
	localparam int          CLK_PERIOD_PS   = 5000;
	localparam int          STEP_FAST_NS    = 20000;
	localparam int          STEP_SLOW_NS    = 40000;
	localparam int          STEP_FAST_CYC   = STEP_FAST_NS * 1000 / CLK_PERIOD_PS;
	localparam int          STEP_SLOW_CYC   = STEP_SLOW_NS * 1000 / CLK_PERIOD_PS;
	localparam int          TICK_W          = 16;

	// Run-time gain change modes in field order.
	typedef enum logic [1:0] {GCM_IMMEDIATE, GCM_NO_STEP, GCM_STEP_FAST, GCM_STEP_SLOW} agcc_gcm_t;

	// State of one gain ramp.
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic [TICK_W-1:0] tick;
	} agcc_ramp_t;

	// Maps a four-bit code onto decibels with a uniform step.
	function automatic logic signed [7:0] agcc_code_db(input logic [3:0] code,
		input logic signed [7:0] base, input logic signed [7:0] step);
		logic signed [7:0] c;
		c = signed'({4'h0, code});
		return 8'(base + c * step);
	endfunction

endpackage

/* verif/agcc_config_sva.sv */
`timescale 1ns/1ps
// Port-level checker for the gain and channel configuration block.
module agcc_config_sva
#(
	parameter int NUM_CH   = 4,
	parameter int FAST_CYC = 4,
	parameter int SLOW_CYC = 8
)
(
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire logic [3:0]           enhancer_trigger_threshold,
	input wire logic [3:0]           enhancer_gain_ceiling,
	input wire logic [3:0]           controller_target_level,
	input wire logic [3:0]           controller_gain_ceiling,
	input wire logic [1:0]           runtime_gain_change_mode,
	input wire logic                 input_chan1_on,
	input wire logic                 input_chan2_on,
	input wire logic                 input_chan3_on,
	input wire logic                 input_chan4_on,
	input wire logic                 level_algorithm_select,
	input wire logic                 compression_on,
	input wire logic signed [7:0]    threshold_db,
	input wire logic signed [7:0]    enhancer_ceiling_db,
	input wire logic signed [7:0]    target_level_db,
	input wire logic signed [7:0]    controller_ceiling_db,
	input wire logic                 controller_active,
	input wire logic [NUM_CH-1:0]    channel_enhancer_on,
	input wire logic [NUM_CH*7-1:0]  requested_gain,
	input wire logic [NUM_CH*7-1:0]  applied_gain
);
	// Helper nets, so that every past value is taken of a plain signal.
	logic       mapped;
	logic       ctl_cause;
	logic [6:0] req0;
	logic [7:0] wdat;
	assign mapped = paddr inside {12'h1b0, 12'h1b4, 12'h1c0, 12'h1c4, 12'h1cc};
	assign ctl_cause = !compression_on && (|channel_enhancer_on) && level_algorithm_select;
	assign req0 = requested_gain[6:0];
	assign wdat = pwdata[7:0];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// A completed write, and a read access phase, at one byte address.
	sequence s_wr(logic [11:0] a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence
	sequence s_rd(logic [11:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence

	// The decoded levels lag their code by one cycle; the first edge after reset is skipped.
	a_thr_db_map: assert property ($past(rst_n) |-> threshold_db == 8'(-12 - 6 * int'($past(enhancer_trigger_threshold))))
		else $error("threshold level decode wrong");
	a_egn_db_map: assert property ($past(rst_n) |-> enhancer_ceiling_db == 8'(2 + 2 * int'($past(enhancer_gain_ceiling))))
		else $error("enhancer ceiling decode wrong");
	a_tgt_db_map: assert property ($past(rst_n) |-> target_level_db == 8'(-6 - 2 * int'($past(controller_target_level))))
		else $error("target level decode wrong");
	a_cgn_db_map: assert property ($past(rst_n) |-> controller_ceiling_db == 8'(3 + 3 * int'($past(controller_gain_ceiling))))
		else $error("controller ceiling decode wrong");
	a_ctl_active_sel: assert property ($past(rst_n) |-> controller_active == $past(ctl_cause))
		else $error("controller active flag wrong");
	a_mode0_at_once: assert property ($past(rst_n) && $past(runtime_gain_change_mode) == 2'h0 |->
		applied_gain[6:0] == (($past(req0) > 7'd84) ? 7'd84 : $past(req0)))
		else $error("immediate gain not applied");
	a_mode_wr_lands: assert property (s_wr(12'h1c4) |=> {runtime_gain_change_mode, 6'h0} == ($past(wdat) & 8'hc0))
		else $error("gain change mode write lost");
	a_chan_wr_lands: assert property (s_wr(12'h1cc) |=> {input_chan1_on, input_chan2_on, input_chan3_on,
		input_chan4_on, 4'h0} == ($past(wdat) & 8'hf0))
		else $error("channel enable write lost");
	a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error flag wrong");
	a_rsv_read_zero: assert property (s_rd(12'h1c4) |-> prdata[4:0] == 5'h0 && prdata[31:8] == 24'h0)
		else $error("reserved bits read nonzero");
endmodule // agcc_config_sva

bind agcc_config agcc_config_sva #(.NUM_CH(NUM_CH), .FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_sva (
	.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr,
	.enhancer_trigger_threshold, .enhancer_gain_ceiling, .controller_target_level, .controller_gain_ceiling,
	.runtime_gain_change_mode, .input_chan1_on, .input_chan2_on, .input_chan3_on, .input_chan4_on,
	.level_algorithm_select, .compression_on, .threshold_db, .enhancer_ceiling_db, .target_level_db,
	.controller_ceiling_db, .controller_active, .channel_enhancer_on, .requested_gain, .applied_gain
);

/* verif/tb_agcc_config.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
// Self-checking bench: APB tasks plus scenarios with worked-out expectations.
module tb_agcc_config;
	import agcc_pkg::*;
	logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, high_impedance_sel;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rdat;
	logic [3:0]        pstrb, enhancer_trigger_threshold, enhancer_gain_ceiling, controller_target_level;
	logic [3:0]        controller_gain_ceiling, channel_enhancer_on, zero_cross;
	logic [1:0]        runtime_gain_change_mode;
	logic              input_chan1_on, input_chan2_on, input_chan3_on, input_chan4_on, rerr;
	logic              level_algorithm_select, compression_on, enhancer_active, controller_active;
	logic signed [7:0] threshold_db, enhancer_ceiling_db, target_level_db, controller_ceiling_db;
	logic [27:0]       requested_gain, applied_gain;
	int                failures, check_count, t, g, k;
	logic [11:0]       addrs [5] = '{12'h1b0, 12'h1b4, 12'h1c0, 12'h1c4, 12'h1cc};
	logic [7:0]        rstv  [5] = '{8'h00, 8'h7b, 8'he7, 8'h00, 8'hc0};

	// Short step counts keep the ramp scenarios brief.
	agcc_config #(.NUM_CH(4), .FAST_CYC(4), .SLOW_CYC(8)) DUT (.*);

	// Free-running 200 MHz clock.
	always #2.5 mclk = ~mclk;

	// Prints the counts and the verdict, then stops the run.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One APB transfer; the request is held until pready is seen, then an idle edge follows.
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {24'h0, d}; pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		// A slave that never answers ends the run rather than hanging it.
		if (n >= 20)
		begin
			failures++;
			tally_and_finish();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, d, 4'h1);
	endtask

	// Reads one register and compares the whole 32-bit word.
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		apb(a, 1'b0, 8'h00, 4'h0);
		`CHK({rerr, rdat}, {1'b0, 24'h0, e})
	endtask

	// Main sequence.
	initial
	begin
		mclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = '0;
		channel_enhancer_on = '0; high_impedance_sel = 0; requested_gain = '0; zero_cross = '0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 5; i++)
			rdchk(addrs[i], rstv[i]);
		`CHK({threshold_db, enhancer_ceiling_db, target_level_db, controller_ceiling_db}, 32'hca18de18)
		`CHK({input_chan1_on, input_chan2_on, input_chan3_on, input_chan4_on, runtime_gain_change_mode}, 6'h30)
		// Sweep every permitted code of the four level fields, boundaries included.
		for (int c = 0; c < 16; c++)
		begin
			t = (c > 9) ? 9 : c;
			g = (c > 12) ? 12 : c;
			k = (c > 13) ? 13 : c;
			// Reserved threshold and ceiling codes are never written.
			wr(12'h1b4, {4'(t), 4'(g)});
			wr(12'h1c0, {4'(c), 4'(k)});
			repeat (2) @(posedge mclk);
			`CHK({threshold_db, enhancer_ceiling_db}, {8'(-12 - 6 * t), 8'(2 + 2 * g)})
			`CHK({target_level_db, controller_ceiling_db}, {8'(-6 - 2 * c), 8'(3 + 3 * k)})
			rdchk(12'h1c0, {4'(c), 4'(k)});
		end
		// Every gain change mode, reserved bits written as zero.
		for (int m = 0; m < 4; m++)
		begin
			wr(12'h1c4, {2'(m), 6'h00});
			`CHK(runtime_gain_change_mode, 2'(m))
			rdchk(12'h1c4, {2'(m), 6'h00});
		end
		// Channel enables, then a write with the byte strobe low that must be ignored.
		wr(12'h1cc, 8'h50);
		`CHK({input_chan1_on, input_chan2_on, input_chan3_on, input_chan4_on}, 4'h5)
		wr(12'h1cc, 8'ha0);
		`CHK({input_chan1_on, input_chan2_on, input_chan3_on, input_chan4_on}, 4'ha)
		apb(12'h1cc, 1'b1, 8'hf0, 4'h0);
		rdchk(12'h1cc, 8'ha0);
		// Unmapped address: error, no data, nothing changes.
		apb(12'h1c8, 1'b1, 8'hff, 4'h1);
		`CHK(rerr, 1'b1)
		`CHK(pready, 1'b1)
		apb(12'h1c8, 1'b0, 8'h00, 4'h0);
		`CHK({rerr, rdat}, {1'b1, 32'h0})
		rdchk(12'h1c4, 8'hc0);
		// Algorithm selection against the compression switch.
		channel_enhancer_on <= 4'h1;
		wr(12'h1b0, 8'h00);
		repeat (2) @(posedge mclk);
		`CHK({enhancer_active, controller_active}, 2'b10)
		wr(12'h1b0, 8'h08);
		repeat (2) @(posedge mclk);
		`CHK({enhancer_active, controller_active}, 2'b01)
		wr(12'h1b0, 8'h0a);
		repeat (2) @(posedge mclk);
		`CHK({enhancer_active, controller_active}, 2'b00)
		rdchk(12'h1b0, 8'h0a);
		// Immediate mode clips at the 42 dB ceiling.
		wr(12'h1c4, 8'h00);
		requested_gain <= {7'd10, 7'd10, 7'd10, 7'd100};
		repeat (3) @(posedge mclk);
		`CHK(applied_gain, {7'd10, 7'd10, 7'd10, 7'd84})
		// Mode 1 waits for the zero crossing, then jumps without steps.
		wr(12'h1c4, 8'h40);
		requested_gain[27:21] <= 7'd20;
		repeat (3) @(posedge mclk);
		`CHK(applied_gain[27:21], 7'd10)
		zero_cross <= 4'h8;
		@(posedge mclk);
		zero_cross <= 4'h0;
		repeat (2) @(posedge mclk);
		`CHK(applied_gain[27:21], 7'd20)
		// Fast stepping toward a target above the 10k limit.
		wr(12'h1c4, 8'h80);
		requested_gain[13:7] <= 7'd70;
		repeat (3) @(posedge mclk);
		`CHK(applied_gain[13:7] < 7'd12, 1'b1)
		repeat (52 * 4 + 10) @(posedge mclk);
		`CHK(applied_gain[13:7], 7'd60)
		// Slow stepping with the 20k input, limited to 24 dB.
		high_impedance_sel <= 1'b1;
		wr(12'h1c4, 8'hc0);
		requested_gain[20:14] <= 7'd70;
		repeat (16) @(posedge mclk);
		`CHK(applied_gain[20:14] < 7'd14, 1'b1)
		repeat (40 * 8 + 10) @(posedge mclk);
		`CHK(applied_gain[20:14], 7'd48)
		tally_and_finish();
	end
endmodule // tb_agcc_config
